// *** rtl/strap_defs.svh ***
// strap_defs.svh: register offsets, field positions, reset values, strap pin map
// assumes it is included by bare name into the files that need these macros
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH
// register byte offsets
`define REG_CONTROL 8'h00
`define REG_ADVERT 8'h04
`define REG_EXT_SETUP 8'h08
`define REG_STRAP_STATUS 8'h0C
// control register fields
`define CTL_SOFT_RST 15
`define CTL_SPEED 13
`define CTL_AN_EN 12
`define CTL_PWR_DOWN 11
`define CTL_ISOLATE 10
`define CTL_DUPLEX 8
`define CTL_WMASK 16'hBD00
`define CTL_RST 16'h0000
// advertisement field, bits 8:5
`define ADV_LSB 5
`define ADV_WMASK 16'h01E0
`define ADV_RST 16'h01E0
// extended setup register fields
`define EXT_ADDR_LSB 0
`define EXT_MODE_LSB 5
`define EXT_IFTYPE 14
`define EXT_WMASK 16'h00FF
`define EXT_RST 16'h0000
// shared pin positions
`define PIN_ADDR0 0
`define PIN_ADDR1 1
`define PIN_ADDR2 2
`define PIN_MODE0 3
`define PIN_MODE2 5
`define PIN_IFSEL 6
`define NUM_SHARED_PINS 7
// control patterns on bits 13,12,10,8 and advert patterns per mode
`define CTL4_M0 4'h0
`define CTL4_M1 4'h1
`define CTL4_M2 4'h8
`define CTL4_M3 4'h9
`define CTL4_M4 4'hC
`define CTL4_M7 4'hD
`define ADV4_M4 4'h4
`define ADV4_M7 4'hF
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/strap_pkg.sv ***
// strap_pkg: types shared by the strap loader files
// assumes strap_defs.svh supplies the numeric constants
package strap_pkg;
  typedef logic [2:0] strap_mode_t;
  typedef logic [3:0] ctl_pattern_t;
  typedef enum logic {LD_HELD, LD_RUN} load_state_t;
endpackage : strap_pkg

// *** rtl/strap_sync.sv ***
// strap_sync: two flip-flop synchroniser for pins from outside the clock domain
// assumes a synchronous active-low reset on the same clock
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic hardware_reset_pin_in,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      meta <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : strap_sync
`default_nettype wire

// *** rtl/strap_mode_decode.sv ***
// strap_mode_decode: maps a three-bit mode value to default register loads
// assumes the caller applies the outputs only at a load event
`timescale 1ns/1ps
`default_nettype none
`include "strap_defs.svh"
module strap_mode_decode
  import strap_pkg::*;
(
  // mode value
  input wire strap_mode_t mode_in,
  // decoded defaults
  output ctl_pattern_t ctl4_out,
  output logic adv_load_out,
  output logic [3:0] adv4_out,
  output logic crs_on_tx_out,
  output logic repeater_out,
  output logic pwr_down_out
);
  // one row per mode; advert reloads its reset value where no load is defined
  always_comb begin
    ctl4_out = `CTL4_M0;
    adv_load_out = 1'b0;
    adv4_out = `ADV4_M4;
    crs_on_tx_out = 1'b1;
    repeater_out = 1'b0;
    pwr_down_out = 1'b0;
    case (mode_in)
      3'h0: ctl4_out = `CTL4_M0;
      3'h1: ctl4_out = `CTL4_M1;
      3'h2: ctl4_out = `CTL4_M2;
      3'h3: begin
        ctl4_out = `CTL4_M3;
        crs_on_tx_out = 1'b0;
      end
      3'h4: begin
        ctl4_out = `CTL4_M4;
        adv_load_out = 1'b1;
      end
      3'h5: begin
        ctl4_out = `CTL4_M4;
        adv_load_out = 1'b1;
        crs_on_tx_out = 1'b0;
        repeater_out = 1'b1;
      end
      3'h6: pwr_down_out = 1'b1;
      3'h7: begin
        ctl4_out = `CTL4_M7;
        adv_load_out = 1'b1;
        adv4_out = `ADV4_M7;
      end
      default: ctl4_out = `CTL4_M0;
    endcase
  end
endmodule : strap_mode_decode
`default_nettype wire

// *** rtl/phy_strap_config_loader.sv ***
// phy_strap_config_loader: latches board straps at reset release and holds
// the control, advertisement and extended setup registers behind AXI4-Lite
// assumes hardware_reset_pin_in is the power-on reset and all pins arrive asynchronously
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "strap_defs.svh"
module phy_strap_config_loader
  import strap_pkg::*;
#(
  parameter int AXI_ADDR_W = 8,
  parameter int NUM_PINS = `NUM_SHARED_PINS
)(
  // clock and power-on reset
  input wire logic clk_sys_in,
  input wire logic hardware_reset_pin_in,
  // board pins
  input wire logic hardware_reset_pin_n_in,
  input wire logic supplies_valid_in,
  input wire logic regulator_disable_strap_in,
  // shared receive pins
  input wire logic [NUM_PINS-1:0] shared_pin_in,
  output logic [NUM_PINS-1:0] shared_pin_out,
  output logic [NUM_PINS-1:0] shared_pin_oe_n_out,
  // receive path values to drive after reset
  input wire logic [NUM_PINS-1:0] rx_drive_in,
  // management frame address check
  input wire logic mgmt_frame_valid_in,
  input wire logic [4:0] mgmt_frame_addr_in,
  output logic mgmt_addr_match_out,
  // configuration towards the core
  output logic core_in_reset_out,
  output logic speed_100_out,
  output logic full_duplex_out,
  output logic autoneg_en_out,
  output logic isolate_out,
  output logic power_down_out,
  output logic [3:0] advert_out,
  output logic crs_on_tx_out,
  output logic repeater_out,
  output logic rmii_sel_out,
  output logic regulator_en_out,
  output logic [4:0] scrambler_seed_out,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // axi4-lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // axi4-lite read
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out
);

  // place a four-bit pattern on control bits 13,12,10,8 plus power down
  function automatic logic [15:0] place_ctl(input ctl_pattern_t bits, input logic pdn);
    logic [15:0] r;
    r = `CTL_RST;
    r[`CTL_SPEED] = bits[3];
    r[`CTL_AN_EN] = bits[2];
    r[`CTL_ISOLATE] = bits[1];
    r[`CTL_DUPLEX] = bits[0];
    r[`CTL_PWR_DOWN] = pdn;
    return r;
  endfunction : place_ctl

  // byte-lane merge of a write, only bits in the mask change
  function automatic logic [15:0] merge_wr(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] r;
    r = old;
    for (int i = 0; i < 2; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = (old[i*8 +: 8] & ~mask[i*8 +: 8]) | (data[i*8 +: 8] & mask[i*8 +: 8]);
      end
    end
    return r;
  endfunction : merge_wr

  // advert field with a new four-bit value
  function automatic logic [15:0] place_adv(input logic load, input logic [3:0] bits);
    logic [15:0] r;
    r = `ADV_RST;
    if (load) begin
      r[`ADV_LSB +: 4] = bits;
    end
    return r;
  endfunction : place_adv

  // synchronised pins
  logic [NUM_PINS-1:0] pin_sync;
  logic hw_pin_sync;
  logic supplies_sync;
  logic regulator_disable_strap_sync;

  // register state
  load_state_t ld_state;
  load_state_t next_ld_state;
  logic [15:0] ctl;
  logic [15:0] adv;
  logic [15:0] ext;
  logic [15:0] next_ctl;
  logic [15:0] next_adv;
  logic [15:0] next_ext;
  logic [2:0] addr_latch;
  logic [2:0] mode_latch;
  logic ifsel_latch;
  logic reg_sampled;

  // bus state
  logic aw_hold;
  logic w_hold;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  strap_sync #(.W(NUM_PINS), .RST_VAL('0)) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .hardware_reset_pin_in(hardware_reset_pin_in),
    .async_in(shared_pin_in),
    .sync_out(pin_sync)
  );

  strap_sync #(.W(3), .RST_VAL(3'h0)) u_ctl_sync (
    .clk_sys_in(clk_sys_in),
    .hardware_reset_pin_in(hardware_reset_pin_in),
    .async_in({hardware_reset_pin_n_in, supplies_valid_in, regulator_disable_strap_in}),
    .sync_out({hw_pin_sync, supplies_sync, regulator_disable_strap_sync})
  );

  // strap decode, used at hardware reset release
  ctl_pattern_t strap_ctl4;
  logic strap_adv_ld;
  logic [3:0] strap_adv4;
  logic strap_crs_tx;
  logic strap_rep;
  logic strap_pdn;
  strap_mode_decode u_strap_dec (
    .mode_in(pin_sync[`PIN_MODE2:`PIN_MODE0]),
    .ctl4_out(strap_ctl4),
    .adv_load_out(strap_adv_ld),
    .adv4_out(strap_adv4),
    .crs_on_tx_out(strap_crs_tx),
    .repeater_out(strap_rep),
    .pwr_down_out(strap_pdn)
  );

  // register-field decode, used at soft reset
  ctl_pattern_t field_ctl4;
  logic field_adv_ld;
  logic [3:0] field_adv4;
  logic field_crs_tx;
  logic field_rep;
  logic field_pdn;
  strap_mode_decode u_field_dec (
    .mode_in(ext[`EXT_MODE_LSB +: 3]),
    .ctl4_out(field_ctl4),
    .adv_load_out(field_adv_ld),
    .adv4_out(field_adv4),
    .crs_on_tx_out(field_crs_tx),
    .repeater_out(field_rep),
    .pwr_down_out(field_pdn)
  );

  // load events and bus decode
  wire release_evt = (ld_state == LD_HELD) && hw_pin_sync;
  wire wr_fire = aw_hold && w_hold && !s_axi_bvalid_out;
  wire wr_ctl = wr_fire && (aw_addr == `REG_CONTROL);
  wire wr_adv = wr_fire && (aw_addr == `REG_ADVERT);
  wire wr_ext = wr_fire && (aw_addr == `REG_EXT_SETUP);
  wire wr_sts = wr_fire && (aw_addr == `REG_STRAP_STATUS);
  wire wr_hit = wr_ctl || wr_adv || wr_ext || wr_sts;
  wire soft_rst = wr_ctl && w_strb[1] && w_data[`CTL_SOFT_RST];
  wire rd_take = s_axi_arvalid_in && s_axi_arready_out;
  wire [15:0] status_word = {4'h0, regulator_en_out, reg_sampled, crs_on_tx_out, repeater_out,
                             ifsel_latch, mode_latch, addr_latch, ld_state == LD_RUN};
  // byte lane bits of the read address are ignored, as on the write side
  wire [AXI_ADDR_W-1:0] ar_word = s_axi_araddr_in & {{(AXI_ADDR_W-2){1'b1}}, 2'b00};
  wire rd_ctl = ar_word == `REG_CONTROL;
  wire rd_adv = ar_word == `REG_ADVERT;
  wire rd_ext = ar_word == `REG_EXT_SETUP;
  wire rd_sts = ar_word == `REG_STRAP_STATUS;
  wire rd_hit = rd_ctl || rd_adv || rd_ext || rd_sts;
  wire [15:0] rd_word = rd_ctl ? ctl : rd_adv ? adv : rd_ext ? ext : rd_sts ? status_word : 16'h0000;
  wire [15:0] strap_ext = {1'b0, pin_sync[`PIN_IFSEL], 6'h00, pin_sync[`PIN_MODE2:`PIN_MODE0],
                           2'h0, pin_sync[`PIN_ADDR2:`PIN_ADDR0]};

  // load sequence: held while the reset pin is low, running after release
  always_comb begin
    next_ld_state = ld_state;
    case (ld_state)
      LD_HELD: if (hw_pin_sync) next_ld_state = LD_RUN;
      LD_RUN: if (!hw_pin_sync) next_ld_state = LD_HELD;
      default: next_ld_state = LD_HELD;
    endcase
  end

  // register next values; strap load, then soft reset, then host writes
  always_comb begin
    next_ctl = ctl;
    next_adv = adv;
    next_ext = ext;
    if (ld_state == LD_HELD) begin
      next_ctl = `CTL_RST;
      next_adv = `ADV_RST;
      next_ext = `EXT_RST;
      if (release_evt) begin
        next_ctl = place_ctl(strap_ctl4, strap_pdn);
        next_adv = place_adv(strap_adv_ld, strap_adv4);
        next_ext = strap_ext;
      end
    end else if (soft_rst) begin
      // address, mode and interface fields survive; the rest reload from the mode field
      next_ctl = place_ctl(field_ctl4, field_pdn);
      next_adv = place_adv(field_adv_ld, field_adv4);
    end else begin
      if (wr_ctl) next_ctl = merge_wr(ctl, w_data, w_strb, `CTL_WMASK & 16'h7FFF);
      if (wr_adv) next_adv = merge_wr(adv, w_data, w_strb, `ADV_WMASK);
      if (wr_ext) next_ext = merge_wr(ext, w_data, w_strb, `EXT_WMASK);
    end
  end

  // load state and configuration registers
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      ld_state <= LD_HELD;
      ctl <= `CTL_RST;
      adv <= `ADV_RST;
      ext <= `EXT_RST;
    end else begin
      ld_state <= next_ld_state;
      ctl <= next_ctl;
      adv <= next_adv;
      ext <= next_ext;
    end
  end

  // latched strap copies; only a new release can change them
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      addr_latch <= 3'h0;
      mode_latch <= 3'h0;
      ifsel_latch <= 1'b0;
    end else if (release_evt) begin
      addr_latch <= pin_sync[`PIN_ADDR2:`PIN_ADDR0];
      mode_latch <= pin_sync[`PIN_MODE2:`PIN_MODE0];
      ifsel_latch <= pin_sync[`PIN_IFSEL];
    end
  end

  // carrier sense and repeater flags follow whichever load happened last
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      crs_on_tx_out <= 1'b1;
      repeater_out <= 1'b0;
    end else if (release_evt) begin
      crs_on_tx_out <= strap_crs_tx;
      repeater_out <= strap_rep;
    end else if (ld_state == LD_RUN && soft_rst) begin
      crs_on_tx_out <= field_crs_tx;
      repeater_out <= field_rep;
    end
  end

  // regulator strap is taken once per power-on, never at a pin reset
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      reg_sampled <= 1'b0;
      regulator_en_out <= 1'b1;
    end else if (supplies_sync && !reg_sampled) begin
      reg_sampled <= 1'b1;
      regulator_en_out <= !regulator_disable_strap_sync;
    end
  end

  // shared pins float while held so the board pulls can be read
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      shared_pin_out <= '0;
      shared_pin_oe_n_out <= '1;
      core_in_reset_out <= 1'b1;
    end else begin
      shared_pin_out <= rx_drive_in;
      shared_pin_oe_n_out <= {NUM_PINS{next_ld_state == LD_HELD}};
      core_in_reset_out <= next_ld_state == LD_HELD;
    end
  end

  // management frames are only claimed at the configured address
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      mgmt_addr_match_out <= 1'b0;
    end else begin
      mgmt_addr_match_out <= (ld_state == LD_RUN) && mgmt_frame_valid_in &&
                             (mgmt_frame_addr_in == ext[`EXT_ADDR_LSB +: 5]);
    end
  end

  // core-facing configuration comes straight from the register flops
  assign speed_100_out = ctl[`CTL_SPEED];
  assign full_duplex_out = ctl[`CTL_DUPLEX];
  assign autoneg_en_out = ctl[`CTL_AN_EN];
  assign isolate_out = ctl[`CTL_ISOLATE];
  assign power_down_out = ctl[`CTL_PWR_DOWN];
  assign advert_out = adv[`ADV_LSB +: 4];
  assign rmii_sel_out = ext[`EXT_IFTYPE];
  assign scrambler_seed_out = ext[`EXT_ADDR_LSB +: 5];

  // write address and data are taken in either order and held until answered
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr_in & {{(AXI_ADDR_W-2){1'b1}}, 2'b00};
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      w_hold <= 1'b0;
    end
  end

  // ready is low while an item is held; reopens after the response is taken
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= !(aw_hold || (s_axi_awvalid_in && s_axi_awready_out)) ||
                           (s_axi_bvalid_out && s_axi_bready_in);
      s_axi_wready_out <= !(w_hold || (s_axi_wvalid_in && s_axi_wready_out)) ||
                          (s_axi_bvalid_out && s_axi_bready_in);
    end
  end

  // write response; unmapped offsets answer slave error and change nothing
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // read channel: one read at a time, data one cycle after the address
  always_ff @(posedge clk_sys_in) begin
    if (!hardware_reset_pin_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {16'h0000, rd_word};
      s_axi_rresp_out <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end else if (!s_axi_rvalid_out) begin
      s_axi_arready_out <= 1'b1;
    end
  end

endmodule : phy_strap_config_loader
`default_nettype wire

// *** dv/strap_loader_sva.sv ***
// strap_loader_sva: port level assertions for the strap loader
// assumes it is bound into every phy_strap_config_loader instance
`timescale 1ns/1ps
`default_nettype none
module strap_loader_sva #(
  parameter int NUM_PINS = 7
)(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic hardware_reset_pin_in,
  // pins
  input wire logic hardware_reset_pin_n_in,
  input wire logic supplies_valid_in,
  input wire logic [NUM_PINS-1:0] rx_drive_in,
  input wire logic [NUM_PINS-1:0] shared_pin_out,
  input wire logic [NUM_PINS-1:0] shared_pin_oe_n_out,
  // management and configuration
  input wire logic mgmt_frame_valid_in,
  input wire logic [4:0] mgmt_frame_addr_in,
  input wire logic mgmt_addr_match_out,
  input wire logic core_in_reset_out,
  input wire logic rmii_sel_out,
  input wire logic regulator_en_out,
  input wire logic [4:0] scrambler_seed_out,
  input wire logic s_axi_bvalid_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!hardware_reset_pin_in);
  // the pin passes two flops, so release is seen a few edges late
  sequence pin_up;
    $rose(hardware_reset_pin_n_in) ##1 hardware_reset_pin_n_in [*2];
  endsequence
  sequence running;
    !core_in_reset_out && !$past(core_in_reset_out);
  endsequence
  a_release_load: assert property (pin_up |-> ##[0:1] !core_in_reset_out)
    else $error("core not released after pin rise");
  a_held_pins: assert property (
    (!hardware_reset_pin_n_in) [*5] |-> core_in_reset_out && &shared_pin_oe_n_out)
    else $error("pins driven while held");
  a_drive_copy: assert property (
    running |-> shared_pin_out == $past(rx_drive_in) && shared_pin_oe_n_out == '0)
    else $error("receive value not on shared pins");
  a_match_hit: assert property (
    mgmt_frame_valid_in && mgmt_frame_addr_in == scrambler_seed_out && !core_in_reset_out
    |=> mgmt_addr_match_out)
    else $error("own frame not matched");
  a_match_miss: assert property (
    !mgmt_frame_valid_in || mgmt_frame_addr_in != scrambler_seed_out |=> !mgmt_addr_match_out)
    else $error("foreign frame matched");
  // only a register write may move the station address once running
  a_seed_hold: assert property (
    !core_in_reset_out && !$past(core_in_reset_out) && !$rose(s_axi_bvalid_out)
    |-> $stable(scrambler_seed_out))
    else $error("station address moved");
  a_iftype_ro: assert property (running |-> $stable(rmii_sel_out))
    else $error("interface type moved");
  a_reg_once: assert property (supplies_valid_in [*6] |=> $stable(regulator_en_out) [*8])
    else $error("regulator resampled");
endmodule : strap_loader_sva
bind phy_strap_config_loader strap_loader_sva #(.NUM_PINS(NUM_PINS)) i_sva (.*);
`default_nettype wire

// *** dv/strap_board_model.sv ***
// strap_board_model: board pull resistors on the shared receive pins
// assumes the loader releases a pin by raising its active-low enable
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
  // pull levels and the loader side of each pin
  input wire logic [6:0] pull_in,
  input wire logic [6:0] oe_n_in,
  input wire logic [6:0] drv_in,
  // resolved pin level
  output logic [6:0] pin_out
);
  // a released pin settles to its pull, a driven one follows the loader
  assign pin_out = (oe_n_in & pull_in) | (~oe_n_in & drv_in);
endmodule : strap_board_model
`default_nettype wire

// *** dv/tb_phy_strap_config_loader.sv ***
// tb_phy_strap_config_loader: strap latching, soft reset and bus checks
// assumes the loader and the board model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_phy_strap_config_loader;
  import strap_pkg::*;
  logic clk_sys_in = 0, hardware_reset_pin_in = 0, hardware_reset_pin_n_in = 0, supplies_valid_in = 0;
  logic regulator_disable_strap_in = 1, mgmt_frame_valid_in = 0;
  logic [6:0] rx_drive_in = 0, pull = 0, shared_pin_in, shared_pin_out, shared_pin_oe_n_out;
  logic [4:0] mgmt_frame_addr_in = 0, scrambler_seed_out;
  logic mgmt_addr_match_out, core_in_reset_out, speed_100_out, full_duplex_out, autoneg_en_out;
  logic isolate_out, power_down_out, crs_on_tx_out, repeater_out, rmii_sel_out, regulator_en_out;
  logic [3:0] advert_out, s_axi_wstrb_in = 0;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0;
  logic s_axi_rready_in = 0, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out;
  logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int bad_count = 0, n_tests = 0;
  logic [3:0] m, ct[8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hC, 4'hC, 4'h0, 4'hD};
  logic [3:0] av[8] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h4, 4'h4, 4'hF, 4'hF};
  logic [2:0] a;
  logic f;

  phy_strap_config_loader i_dut (.*);
  strap_board_model i_board (.pull_in(pull), .oe_n_in(shared_pin_oe_n_out), .drv_in(shared_pin_out),
    .pin_out(shared_pin_in));

  // clock and random receive traffic on the shared pins
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) rx_drive_in <= 7'($urandom);

  task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick

  // answers are compared in arrival order against the notes of the drivers
  always @(posedge clk_sys_in) begin
    if (s_axi_rvalid_out === 1'h1 && s_axi_rready_in) begin
      chk("read", {s_axi_rresp_out, s_axi_rdata_out}, rq.pop_front());
    end
    if (s_axi_bvalid_out === 1'h1 && s_axi_bready_in) chk("bresp", s_axi_bresp_out, bq.pop_front());
  end

  // address and data are offered together and dropped each when taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    bit aw_open;
    bit w_open;
    aw_open = 1;
    w_open = 1;
    bq.push_back(r);
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    s_axi_awaddr_in <= ad;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= s;
    s_axi_bready_in <= 1;
    // local flags: the valid signals themselves only change after this time step
    while (aw_open || w_open) begin
      @(posedge clk_sys_in);
      if (aw_open && s_axi_awready_out === 1'h1) begin
        aw_open = 0;
        s_axi_awvalid_in <= 0;
      end
      if (w_open && s_axi_wready_out === 1'h1) begin
        w_open = 0;
        s_axi_wvalid_in <= 0;
      end
    end
    while (s_axi_bvalid_out !== 1'h1) @(posedge clk_sys_in);
    s_axi_bready_in <= 0;
    tick(1);
  endtask : wr

  task rd(input logic [7:0] ad, input logic [33:0] e);
    rq.push_back(e);
    s_axi_arvalid_in <= 1;
    s_axi_araddr_in <= ad;
    s_axi_rready_in <= 1;
    do @(posedge clk_sys_in); while (s_axi_arready_out !== 1'h1);
    s_axi_arvalid_in <= 0;
    do @(posedge clk_sys_in); while (s_axi_rvalid_out !== 1'h1);
    s_axi_rready_in <= 0;
    tick(1);
  endtask : rd

  // pin reset with straps set; the pulls flip afterwards to show they are ignored
  task boot(input logic [6:0] p);
    pull <= p;
    hardware_reset_pin_n_in <= 0;
    tick(8);
    chk("held", {core_in_reset_out, shared_pin_oe_n_out}, 8'hFF);
    hardware_reset_pin_n_in <= 1;
    do @(posedge clk_sys_in); while (core_in_reset_out !== 1'h0);
    pull <= ~p;
    tick(2);
  endtask : boot

  task mframe(input logic [4:0] ad, input logic e);
    mgmt_frame_valid_in <= 1;
    mgmt_frame_addr_in <= ad;
    tick(1);
    mgmt_frame_valid_in <= 0;
    tick(1);
    chk("match", mgmt_addr_match_out, e);
  endtask : mframe

  // watchdog: the whole run needs well under two thousand cycles
  initial begin
    #40000;
    bad_count++;
    end_sim();
  end

  initial begin
    a = 3'($urandom(32'h46b2));
    tick(12);
    hardware_reset_pin_in <= 1;
    supplies_valid_in <= 1;
    tick(10);
    chk("reg off", regulator_en_out, 1'h0);
    regulator_disable_strap_in <= 0;
    for (m = 0; m < 8; m++) begin
      a = 3'($urandom_range(7));
      f = 1'($urandom_range(1));
      boot({f, m[2:0], a});
      chk("ctl", {speed_100_out, autoneg_en_out, isolate_out, full_duplex_out}, ct[m]);
      chk("adv", advert_out, av[m]);
      chk("pd rep", {power_down_out, repeater_out}, {m == 6, m == 5});
      if (m inside {[2:5]}) chk("crs", crs_on_tx_out, m == 2 || m == 4);
      chk("ifsel", rmii_sel_out, f);
      chk("seed", scrambler_seed_out, {2'h0, a});
      rd(8'h08, {19'h0, f, 6'h0, m[2:0], 2'h0, a});
      // latched copies must survive the random receive traffic on the shared pins
      rd(8'h0C, {22'h0, 2'h1, m != 3 && m != 5, m == 5, f, m[2:0], a, 1'h1});
      mframe({2'h0, a}, 1);
      mframe({2'h0, a} ^ 5'h1, 0);
    end
    boot({1'h0, 3'h6, 3'h2});
    wr(8'h08, 32'h0000_0069, 4'h1, 2'h0);
    mframe(5'h09, 1);
    wr(8'h00, 32'h0000_8000, 4'h2, 2'h0);
    chk("soft", {power_down_out, speed_100_out, full_duplex_out, crs_on_tx_out}, 4'h6);
    rd(8'h08, {2'h0, 32'h0000_0069});
    wr(8'h00, 32'h0000_0100, 4'h3, 2'h0);
    rd(8'h00, {2'h0, 32'h0000_0100});
    wr(8'h04, 32'h0000_0020, 4'h3, 2'h0);
    chk("adv wr", advert_out, 4'h1);
    wr(8'h10, 32'hFFFF_FFFF, 4'hF, 2'h2);
    rd(8'h10, {2'h2, 32'h0});
    chk("reg once", regulator_en_out, 1'h0);
    hardware_reset_pin_in <= 0;
    tick(12);
    hardware_reset_pin_in <= 1;
    tick(10);
    chk("reg on", regulator_en_out, 1'h1);
    end_sim();
  end
endmodule : tb_phy_strap_config_loader
`default_nettype wire
